// ===== common/idps_pkg.sv
// Package of constants for the interface detect and power select block
package idps_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDPS_OFS_OVERRIDE = 8'h0f;
  localparam logic [7:0] IDPS_OFS_POWER    = 8'h14;
  localparam logic [7:0] IDPS_OFS_STATUS   = 8'h15;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned IDPS_BIT_OVERRIDE = 2;
  localparam int unsigned IDPS_BIT_CHOICE   = 1;
  localparam int unsigned IDPS_BIT_PWR_ON   = 1;
  localparam int unsigned IDPS_BIT_LINE     = 7;
  localparam int unsigned IDPS_BIT_GREEN    = 6;
  localparam int unsigned IDPS_BIT_FRAME    = 5;
  localparam int unsigned IDPS_BIT_LINKCLK  = 4;
  localparam logic [7:0]  IDPS_RST_OVERRIDE = 8'h00;
  localparam logic [7:0]  IDPS_RST_POWER    = 8'h02;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned IDPS_CLK_MHZ     = 100;
  localparam int unsigned IDPS_LOSS_MS     = 100;
  localparam int unsigned IDPS_LOSS_CYC    = IDPS_LOSS_MS * 1000 * IDPS_CLK_MHZ;
  localparam int unsigned IDPS_STRB_RUN     = 32;
  localparam int unsigned IDPS_STRB_GAP_CYC = 4096;

  // Active interface
  typedef enum logic [1:0] {
    IDPS_ACT_NONE    = 2'b00,
    IDPS_ACT_ANALOG  = 2'b01,
    IDPS_ACT_DIGITAL = 2'b10
  } idps_act_e;

  // Digital detect stages
  typedef enum logic [1:0] {
    IDPS_DG_SEEK  = 2'b00,
    IDPS_DG_COUNT = 2'b01,
    IDPS_DG_DONE  = 2'b10
  } idps_dg_e;

endpackage

// ===== rtl/idps_top.sv
// Interface detect and power select logic with its register port
`timescale 1ns/10ps
module idps_top import idps_pkg::*; #(
  parameter int unsigned LOSS_CYC = IDPS_LOSS_CYC,
  parameter int unsigned GAP_CYC  = IDPS_STRB_GAP_CYC,
  parameter int unsigned STRB_RUN = IDPS_STRB_RUN
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Register port from the serial bus engine
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Activity pins
  input  wire logic       line_sync_i,
  input  wire logic       frame_sync_i,
  input  wire logic       green_embedded_sync_i,
  input  wire logic       link_clk_i,
  input  wire logic       pixel_valid_strobe_i,
  // Power enables and active interface code
  output logic            analog_pwr_o,
  output logic            digital_pwr_o,
  output logic            analog_det_pwr_o,
  output logic            linkclk_det_pwr_o,
  output logic            bandgap_pwr_o,
  output logic [1:0]      active_if_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Run counter is eight bits wide, so longer runs cannot be served
  if (LOSS_CYC < 4 || GAP_CYC < 4 || STRB_RUN < 2 || STRB_RUN > 255) begin : g_bad
    $error("idps_top: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 5;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_edge;

  // Two stages before use; a third holds history for edge detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= {pixel_valid_strobe_i, link_clk_i, green_embedded_sync_i, frame_sync_i, line_sync_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_edge = pin_s2_r & ~pin_s3_r;

  // ----------------------------------------------------------------
  // Presence detectors: a rising edge renews a loss timer
  // ----------------------------------------------------------------
  // Link clock must be slower than half clk_i to be seen; fine for a detector
  localparam int unsigned NDET = 4;
  localparam int unsigned TW   = $clog2(LOSS_CYC + 1);
  logic [TW-1:0]   loss_cnt_r [NDET];
  logic [NDET-1:0] present_r;

  // Detectors run regardless of power state so a link is always seen
  for (genvar g = 0; g < NDET; g++) begin : g_det
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        loss_cnt_r[g] <= '0;
        present_r[g]  <= 1'b0;
      end else if (pin_edge[g]) begin
        loss_cnt_r[g] <= TW'(LOSS_CYC - 1);
        present_r[g]  <= 1'b1;
      end else if (loss_cnt_r[g] != '0) begin
        loss_cnt_r[g] <= loss_cnt_r[g] - TW'(1);
      end else begin
        present_r[g]  <= 1'b0;
      end
    end
  end

  logic line_p;
  logic frame_p;
  logic green_p;
  logic linkclk_p;
  assign line_p    = present_r[0];
  assign frame_p   = present_r[1];
  assign green_p   = present_r[2];
  assign linkclk_p = present_r[3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] override_r;
  logic [7:0] power_r;
  logic [7:0] status;

  // Writes to the two control registers; status is read only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      override_r <= IDPS_RST_OVERRIDE;
      power_r    <= IDPS_RST_POWER;
    end else if (reg_wr_i) begin
      if (reg_addr_i == IDPS_OFS_OVERRIDE) override_r <= reg_wdata_i;
      if (reg_addr_i == IDPS_OFS_POWER)    power_r    <= reg_wdata_i;
    end
  end

  logic ovr_bit;
  logic choice_bit;
  logic pwr_on;
  assign ovr_bit    = override_r[IDPS_BIT_OVERRIDE];
  assign choice_bit = override_r[IDPS_BIT_CHOICE];
  assign pwr_on     = power_r[IDPS_BIT_PWR_ON];

  // Status word assembly
  always_comb begin
    status                    = 8'h00;
    status[IDPS_BIT_LINE]     = line_p;
    status[IDPS_BIT_GREEN]    = green_p;
    status[IDPS_BIT_FRAME]    = frame_p;
    status[IDPS_BIT_LINKCLK]  = linkclk_p;
  end

  // Read data registered; unmapped addresses return zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        IDPS_OFS_OVERRIDE: reg_rdata_o <= override_r;
        IDPS_OFS_POWER:    reg_rdata_o <= power_r;
        IDPS_OFS_STATUS:   reg_rdata_o <= status;
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Digital second stage: consecutive strobe count
  // ----------------------------------------------------------------
  localparam int unsigned GW = $clog2(GAP_CYC + 1);
  idps_dg_e      dg_r;
  logic [7:0]    strb_cnt_r;
  logic [GW-1:0] gap_r;

  // A gap with no strobe for GAP_CYC cycles breaks the run
  // A too short gap setting would break runs of a slow link; keep it above one line time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dg_r       <= IDPS_DG_SEEK;
      strb_cnt_r <= 8'h00;
      gap_r      <= '0;
    end else if (!linkclk_p) begin
      dg_r       <= IDPS_DG_SEEK;
      strb_cnt_r <= 8'h00;
      gap_r      <= '0;
    end else begin
      unique case (dg_r)
        IDPS_DG_SEEK: begin
          dg_r <= IDPS_DG_COUNT;
        end
        IDPS_DG_COUNT: begin
          if (pin_edge[4]) begin
            gap_r <= '0;
            if (strb_cnt_r == 8'(STRB_RUN - 1)) begin
              dg_r <= IDPS_DG_DONE;
            end else begin
              strb_cnt_r <= strb_cnt_r + 8'h01;
            end
          end else if (gap_r == GW'(GAP_CYC - 1)) begin
            strb_cnt_r <= 8'h00;
            gap_r    <= '0;
          end else begin
            gap_r <= gap_r + GW'(1);
          end
        end
        IDPS_DG_DONE: begin
          dg_r <= IDPS_DG_DONE;
        end
        default: dg_r <= IDPS_DG_SEEK;
      endcase
    end
  end

  logic ana_det;
  logic dig_det;
  assign ana_det = line_p | frame_p | green_p;
  assign dig_det = (dg_r == IDPS_DG_DONE);

  // ----------------------------------------------------------------
  // Power state resolution
  // ----------------------------------------------------------------
  idps_act_e act_nxt;

  // Power-down first, override next, automatic choice last
  always_comb begin
    if (!pwr_on) begin
      act_nxt = IDPS_ACT_NONE;
    end else if (ovr_bit) begin
      act_nxt = choice_bit ? IDPS_ACT_DIGITAL : IDPS_ACT_ANALOG;
    end else if (ana_det && dig_det) begin
      act_nxt = choice_bit ? IDPS_ACT_DIGITAL : IDPS_ACT_ANALOG;
    end else if (ana_det) begin
      act_nxt = IDPS_ACT_ANALOG;
    end else if (dig_det) begin
      act_nxt = IDPS_ACT_DIGITAL;
    end else begin
      act_nxt = IDPS_ACT_NONE;
    end
  end

  // Registered enables; only one interface is ever powered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_if_o       <= IDPS_ACT_NONE;
      analog_pwr_o      <= 1'b0;
      digital_pwr_o     <= 1'b0;
      analog_det_pwr_o  <= 1'b0;
      linkclk_det_pwr_o <= 1'b0;
      bandgap_pwr_o     <= 1'b0;
    end else begin
      active_if_o       <= act_nxt;
      analog_pwr_o      <= (act_nxt == IDPS_ACT_ANALOG);
      // Receiver also runs while stage two counts strobes, if powered, not overridden and no analog sync is present
      digital_pwr_o     <= (act_nxt == IDPS_ACT_DIGITAL) ||
                           (pwr_on && !ovr_bit && !ana_det && dg_r == IDPS_DG_COUNT);
      analog_det_pwr_o  <= pwr_on;
      linkclk_det_pwr_o <= pwr_on;
      bandgap_pwr_o     <= (act_nxt != IDPS_ACT_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_one_active: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(analog_pwr_o && digital_pwr_o))
    else $error("both interfaces active");

  a_pdown_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !pwr_on |=> active_if_o == IDPS_ACT_NONE)
    else $error("power-down did not win");

  a_override_sel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pwr_on && ovr_bit) |=> active_if_o == ($past(choice_bit) ? IDPS_ACT_DIGITAL : IDPS_ACT_ANALOG))
    else $error("override select ignored");

  a_none_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!ovr_bit && !ana_det && !dig_det) |=> active_if_o == IDPS_ACT_NONE)
    else $error("idle did not power down");

  a_ana_auto: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pwr_on && !ovr_bit && ana_det && !dig_det) |=> active_if_o == IDPS_ACT_ANALOG)
    else $error("analog not chosen");

  a_both_prio: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pwr_on && !ovr_bit && ana_det && dig_det && !choice_bit) |=> active_if_o == IDPS_ACT_ANALOG)
    else $error("both detected priority wrong");

  a_clk_loss: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (linkclk_p && loss_cnt_r[3] == '0 && !pin_edge[3]) |=> !linkclk_p)
    else $error("link clock presence not cleared");

  a_sync_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pin_edge[0] |=> line_p)
    else $error("line sync not reported");

  a_run_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !linkclk_p |=> (strb_cnt_r == 8'h00 && dg_r == IDPS_DG_SEEK))
    else $error("strobe run not restarted");

  a_lclk_det_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (active_if_o == IDPS_ACT_ANALOG) |-> linkclk_det_pwr_o)
    else $error("clock detector off in analog");

  // ----------------------------------------------------------------
  // Detector, stage and register checks
  // ----------------------------------------------------------------
  // Each sync presence drops once its loss timer has run out
  a_line_loss: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (line_p && loss_cnt_r[0] == '0 && !pin_edge[0]) |=> !line_p)
    else $error("line sync presence not cleared");

  a_frame_loss: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (frame_p && loss_cnt_r[1] == '0 && !pin_edge[1]) |=> !frame_p)
    else $error("frame sync presence not cleared");

  a_green_loss: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (green_p && loss_cnt_r[2] == '0 && !pin_edge[2]) |=> !green_p)
    else $error("green sync presence not cleared");

  // The clock detector is not gated by any power enable
  a_lclk_seen: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pin_edge[3] |=> linkclk_p)
    else $error("link clock not detected");

  a_status_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == IDPS_OFS_STATUS) |=> reg_rdata_o == $past(status))
    else $error("status read mismatch");

  a_stage_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (linkclk_p && dg_r == IDPS_DG_SEEK) |=> dg_r == IDPS_DG_COUNT)
    else $error("second stage not started");

  a_rx_power: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pwr_on && !ovr_bit && !ana_det && dg_r == IDPS_DG_COUNT) |=> digital_pwr_o)
    else $error("receiver not powered for stage two");

  a_run_done: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (linkclk_p && dg_r == IDPS_DG_COUNT && pin_edge[4] && strb_cnt_r == 8'(STRB_RUN - 1)) |=> dig_det)
    else $error("full strobe run not accepted");

  a_run_early: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (dg_r == IDPS_DG_COUNT && strb_cnt_r != 8'(STRB_RUN - 1)) |=> !dig_det)
    else $error("digital detect before full run");

  a_gap_break: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (dg_r == IDPS_DG_COUNT && !pin_edge[4] && gap_r == GW'(GAP_CYC - 1)) |=> strb_cnt_r == 8'h00)
    else $error("gap did not break strobe run");

  // Power state follows the detectors and the control registers
  a_dig_auto: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pwr_on && !ovr_bit && !ana_det && dig_det) |=> active_if_o == IDPS_ACT_DIGITAL)
    else $error("digital not chosen");

  a_pdown_all: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !pwr_on |=> !(analog_pwr_o || digital_pwr_o || analog_det_pwr_o || linkclk_det_pwr_o || bandgap_pwr_o))
    else $error("power-down left an enable on");

  a_bg_digital: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (active_if_o == IDPS_ACT_DIGITAL) |-> (bandgap_pwr_o && analog_det_pwr_o))
    else $error("reference or sync detectors off in digital");

endmodule // idps_top

// ===== verification/idps_host.sv
// Host controller model that reaches the block registers through the strobe port
`timescale 1ns/10ps
module idps_host #(
  parameter int unsigned IDLE = 1
) (
  // Clock
  input  wire logic       clk_i,
  // Register port toward the block
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Quiet bus from time zero so nothing is taken during reset
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One-cycle write strobe; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
    repeat (IDLE) @(negedge clk_i);
  endtask

  // One-cycle read strobe; data is taken a full cycle later, it holds until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    @(negedge clk_i);
    d = reg_rdata_i;
    repeat (IDLE) @(negedge clk_i);
  endtask
endmodule // idps_host

// ===== verification/interface_detect_power_select_bench.sv
// Self-checking bench for the interface detect and power select block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module interface_detect_power_select_bench import idps_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and expected output patterns
  // ----------------------------------------------------------------
  localparam int unsigned LOSS = 50;
  // Pattern is {active, analog, digital, analog det, link det, bandgap}
  localparam logic [6:0]  O_IDLE = 7'h06;
  localparam logic [6:0]  O_ANA  = 7'h37;
  localparam logic [6:0]  O_DIG  = 7'h4f;
  localparam logic [6:0]  O_STG  = 7'h0e;
  localparam logic [6:0]  O_OFF  = 7'h00;
  logic       clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       reg_wr, reg_rd, strb = 1'b0, lclk_en = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] sync_en = 3'h0;
  logic [3:0] cnt = 4'h0;
  logic       an_pwr, dg_pwr, adet_pwr, ldet_pwr, bg_pwr;
  logic [1:0] act;
  wire  [6:0] outs_w = {act, an_pwr, dg_pwr, adet_pwr, ldet_pwr, bg_pwr};
  int         err_count = 0;
  int         checked = 0;

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;
  // Pin pattern counter; sync period of 16 cycles stays well inside the loss window
  always @(negedge clk_i) cnt <= cnt + 4'h1;

  idps_host #(.IDLE(1)) host (
    .clk_i       (clk_i),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_rdata_i (reg_rdata)
  );
  // Short loss window and gap so detection and loss fit a short run
  idps_top #(.LOSS_CYC(LOSS), .GAP_CYC(16), .STRB_RUN(32)) dut (
    .clk_i                 (clk_i),
    .nrst_i                (nrst_i),
    .reg_wr_i              (reg_wr),
    .reg_rd_i              (reg_rd),
    .reg_addr_i            (reg_addr),
    .reg_wdata_i           (reg_wdata),
    .reg_rdata_o           (reg_rdata),
    .line_sync_i           (sync_en[0] & cnt[3]),
    .frame_sync_i          (sync_en[2] & cnt[3]),
    .green_embedded_sync_i (sync_en[1] & cnt[3]),
    .link_clk_i            (lclk_en & cnt[1]),
    .pixel_valid_strobe_i  (strb),
    .analog_pwr_o          (an_pwr),
    .digital_pwr_o         (dg_pwr),
    .analog_det_pwr_o      (adet_pwr),
    .linkclk_det_pwr_o     (ldet_pwr),
    .bandgap_pwr_o         (bg_pwr),
    .active_if_o           (act)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    host.rd(a, d);
    `CHK("register read", ex, d)
  endtask
  // Write, then let the register and the registered outputs settle
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] v, input logic [6:0] ex);
    host.wr(a, v);
    idle(4);
    `CHK("power outputs", ex, outs_w)
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk_i) strb = 1'b1;
      @(negedge clk_i) strb = 1'b0;
      @(negedge clk_i);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard: an overrun counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(2);
    nrst_i = 1'b1;
    chk_reg(IDPS_OFS_OVERRIDE, IDPS_RST_OVERRIDE);
    chk_reg(IDPS_OFS_POWER, IDPS_RST_POWER);
    host.wr(8'h33, 8'hff);
    host.wr(IDPS_OFS_STATUS, 8'hff);
    chk_reg(IDPS_OFS_STATUS, 8'h00);
    chk_reg(8'h33, 8'h00);
    wr_chk(8'h33, 8'h00, O_IDLE);
    // Each analog sync alone must raise its own bit and select analog, then age out
    for (int i = 0; i < 3; i++) begin
      sync_en = 3'h1 << i;
      idle(24);
      chk_reg(IDPS_OFS_STATUS, 8'h80 >> i);
      wr_chk(8'h33, 8'h00, O_ANA);
      sync_en = 3'h0;
      idle(LOSS + 30);
      chk_reg(IDPS_OFS_STATUS, 8'h00);
      wr_chk(8'h33, 8'h00, O_IDLE);
    end
    // Link clock first, receiver off: the first stage must still see it
    lclk_en = 1'b1;
    idle(24);
    chk_reg(IDPS_OFS_STATUS, 8'h10);
    wr_chk(8'h33, 8'h00, O_STG);
    // A broken run of strobes must not complete detection
    pulses(31);
    idle(30);
    pulses(31);
    wr_chk(8'h33, 8'h00, O_STG);
    pulses(1);
    wr_chk(8'h33, 8'h00, O_DIG);
    // Both detected: the choice bit sets priority, then the override forces it
    sync_en = 3'h1;
    idle(24);
    chk_reg(IDPS_OFS_STATUS, 8'h90);
    wr_chk(IDPS_OFS_OVERRIDE, 8'h00, O_ANA);
    wr_chk(IDPS_OFS_OVERRIDE, 8'h02, O_DIG);
    wr_chk(IDPS_OFS_OVERRIDE, 8'h04, O_ANA);
    wr_chk(IDPS_OFS_OVERRIDE, 8'h06, O_DIG);
    chk_reg(IDPS_OFS_OVERRIDE, 8'h06);
    // Power-down beats the override
    wr_chk(IDPS_OFS_POWER, 8'h00, O_OFF);
    chk_reg(IDPS_OFS_POWER, 8'h00);
    wr_chk(IDPS_OFS_POWER, 8'h02, O_DIG);
    wr_chk(IDPS_OFS_OVERRIDE, 8'h00, O_ANA);
    sync_en = 3'h0;
    idle(LOSS + 30);
    wr_chk(8'h33, 8'h00, O_DIG);
    lclk_en = 1'b0;
    idle(LOSS + 30);
    chk_reg(IDPS_OFS_STATUS, 8'h00);
    wr_chk(8'h33, 8'h00, O_IDLE);
    // Override with no activity forces the analog side up
    wr_chk(IDPS_OFS_OVERRIDE, 8'h04, O_ANA);
    end_sim;
  end
endmodule // interface_detect_power_select_bench
